// ===== hw/plr_defines.vh
// Purpose: constants for the power loss recovery controller
// Assumes: 100 MHz clock from the standby domain
// Notes: timing counts are derived from times in their own units
// Contract
// R1: Keep sampling standby rail after off
// R2: Standby steady 30 s means orderly off
// R3: Standby lost within 30 s means loss
// R4: Always-on mode powers up after loss
// R5: Stay-off mode keeps system off after loss
// R6: Previous-state mode restores held state
// R7: Window runs only in previous-state mode
// R8: Loss soon after shutdown may record on
// R9: No standby rail disables recovery modes
// R10: Low button level toggles system power
// R11: Button response selectable by firmware
// R12: Suspend output low off, high on
// R13: No-standby carrier leaves button open
// R14: Own power-good when input unconnected
// R15: Keep state and mode in retained storage; only the on state is retained, mode comes from recoveryMode
// R16: One decision per return; loss restarts
`ifndef PLR_DEFINES_VH
`define PLR_DEFINES_VH

// ----------------------------------------
// Recovery modes
// ----------------------------------------
`define PLR_MODE_ON 2'h0
`define PLR_MODE_OFF 2'h1
`define PLR_MODE_LAST 2'h2

// ----------------------------------------
// Button response modes
// ----------------------------------------
`define PLR_BTN_TOGGLE 2'h0
`define PLR_BTN_ON_ONLY 2'h1
`define PLR_BTN_IGNORE 2'h2

// ----------------------------------------
// Timing
// ----------------------------------------
`define PLR_CLK_HZ 32'h05F5E100
`define PLR_WINDOW_S 32'h0000001E
// 30 s at 100 MHz, written out so the product cannot overflow a 32-bit integer
`define PLR_WINDOW_CYC 32'hB2D05E00

// ----------------------------------------
// Retained storage layout
// ----------------------------------------
`define PLR_RET_WORDS 4
`define PLR_RET_ADDR_W 2
`define PLR_RET_STATE 2'h0
`define PLR_RET_STATE_ON_BIT 0
`define PLR_RESET_STATE 8'h00

`endif

// ===== hw/plr_power_loss_ctrl.v
// Purpose: board controller power loss recovery and button control
// Assumes: inputs synchronous to clock; button already debounced
// Notes: runs from the standby domain; storage survives rail loss
`timescale 1ns/100ps
`include "plr_defines.vh"
module plr_power_loss_ctrl #(
   parameter WINDOW_CYC = `PLR_WINDOW_CYC,
   parameter CNT_W = 32
) (
   // Clock and reset
   input wire clock,
   input wire sys_rst,
   // Carrier pins
   input wire power_button_n,
   input wire power_good_in,
   input wire powerGoodConnected,
   input wire standby_5v_rail,
   input wire standbySupported,
   output wire suspend_rail_off_n,
   // Firmware settings
   input wire [1:0] recoveryMode,
   input wire [1:0] buttonMode,
   input wire osShutdownReq,
   input wire osWakeReq,
   // Internal supply monitors
   input wire inputRailOk,
   input wire moduleRailsOk,
   // Status
   output reg powerGood_ff,
   output reg acLossSeen_ff,
   output reg orderlyOff_ff,
   output reg windowBusy_ff
);
   // ----------------------------------------
   // Sequencer states
   // ----------------------------------------
   localparam ST_BOOT = 3'h0;   // Standby just returned
   localparam ST_READ = 3'h1;   // Decide from retained read
   localparam ST_ON = 3'h2;     // Main rails on
   localparam ST_OFF = 3'h3;    // Main rails off, no window running
   localparam ST_WATCH = 3'h4;  // Monitoring window running

   reg [2:0] state_ff; // Current state
   reg [2:0] nxt_state;
   reg [CNT_W-1:0] winCnt_ff; // Window counter
   reg [CNT_W-1:0] nxt_winCnt;
   reg mainOn_ff; // Rail command
   reg nxt_mainOn;
   reg btnPrev_ff; // Button edge memory
   reg stbPrev_ff; // Standby edge memory
   reg memWrEn; // Retained write strobe
   reg [7:0] memWrData; // Retained write value
   reg winDone; // Window ran to its end this cycle
   wire [7:0] memRdData; // Retained read value
   wire btnPress; // Falling edge of button
   wire stbLost; // Standby dropped this cycle
   wire btnReq; // Accepted button request

   // Retained last-state store
   plr_retain_mem #(.WIDTH(8), .ADDR_W(`PLR_RET_ADDR_W)) uMem (
      .clock(clock),
      .wrEn(memWrEn),
      .wrAddr(`PLR_RET_STATE),
      .wrData(memWrData),
      .rdAddr(`PLR_RET_STATE),
      .rdData_ff(memRdData)
   ); // see R15

   // ----------------------------------------
   // Request decode
   // ----------------------------------------
   assign btnPress = btnPrev_ff & ~power_button_n; // see R10
   assign stbLost = stbPrev_ff & ~standby_5v_rail; // see R1

   // Button response per firmware setting
   function btn_accept;
      input [1:0] mode;
      input on;
      begin
         case (mode)
            `PLR_BTN_TOGGLE: btn_accept = 1'b1;
            `PLR_BTN_ON_ONLY: btn_accept = ~on;
            default: btn_accept = 1'b0;
         endcase
      end
   endfunction
   assign btnReq = btnPress & btn_accept(buttonMode, mainOn_ff); // see R11

   // Rail output, low means off
   assign suspend_rail_off_n = mainOn_ff; // see R12

   // ----------------------------------------
   // Next-state logic
   // ----------------------------------------
   always @* begin
      nxt_state = state_ff;
      nxt_winCnt = winCnt_ff;
      nxt_mainOn = mainOn_ff;
      memWrEn = 1'b0;
      memWrData = `PLR_RESET_STATE;
      winDone = 1'b0;
      case (state_ff)
         ST_BOOT: begin
            // Wait one cycle for registered read
            nxt_state = ST_READ; // see R16
         end
         ST_READ: begin
            // Single recovery decision
            if (!standbySupported) begin
               // No standby: rails follow supply
               nxt_mainOn = 1'b1; // see R9
            end else begin
               case (recoveryMode)
                  `PLR_MODE_ON: nxt_mainOn = 1'b1; // see R4
                  `PLR_MODE_OFF: nxt_mainOn = 1'b0; // see R5
                  `PLR_MODE_LAST: nxt_mainOn = memRdData[`PLR_RET_STATE_ON_BIT]; // see R6
                  default: nxt_mainOn = 1'b0;
               endcase
            end
            nxt_state = nxt_mainOn ? ST_ON : ST_OFF;
         end
         ST_ON: begin
            // Remember on state while running
            memWrEn = 1'b1;
            memWrData = 8'h01; // see R8
            if (btnReq || osShutdownReq) begin
               nxt_mainOn = 1'b0;
               nxt_winCnt = {CNT_W{1'b0}};
               // Window only in previous-state mode
               if (standbySupported && recoveryMode == `PLR_MODE_LAST) begin
                  nxt_state = ST_WATCH; // see R7
               end else begin
                  nxt_state = ST_OFF;
               end
            end
         end
         ST_WATCH: begin
            // Stored state stays on until window proves orderly off or mode leaves previous-state
            if (btnReq || osWakeReq) begin
               nxt_mainOn = 1'b1;
               nxt_state = ST_ON;
            end else if (!standbySupported || recoveryMode != `PLR_MODE_LAST) begin
               // Mode left previous-state: drop the window, record off
               memWrEn = 1'b1;
               memWrData = 8'h00;
               nxt_state = ST_OFF; // see R7
            end else if (winCnt_ff >= WINDOW_CYC - 1) begin
               memWrEn = 1'b1;
               memWrData = 8'h00; // see R2
               winDone = 1'b1;
               nxt_state = ST_OFF;
            end else begin
               nxt_winCnt = winCnt_ff + 1'b1;
            end
         end
         ST_OFF: begin
            // Power-on request
            if (btnReq || osWakeReq) begin
               nxt_mainOn = 1'b1;
               nxt_state = ST_ON;
            end
         end
         default: begin
            nxt_state = ST_BOOT;
            nxt_mainOn = 1'b0;
         end
      endcase
      // Rail loss aborts and restarts classification
      if (!standby_5v_rail) begin
         nxt_mainOn = 1'b0;
         nxt_winCnt = {CNT_W{1'b0}};
         nxt_state = ST_BOOT; // see R16
         if (state_ff != ST_WATCH) begin
            memWrEn = 1'b0;
         end
      end
   end

   // ----------------------------------------
   // State registers
   // ----------------------------------------
   always @(posedge clock) begin
      if (sys_rst) begin
         state_ff <= ST_BOOT;
         winCnt_ff <= {CNT_W{1'b0}};
         mainOn_ff <= 1'b0;
         btnPrev_ff <= 1'b1;
         stbPrev_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         winCnt_ff <= nxt_winCnt;
         mainOn_ff <= nxt_mainOn;
         btnPrev_ff <= power_button_n;
         stbPrev_ff <= standby_5v_rail;
      end
   end

   // ----------------------------------------
   // Status and power-good
   // ----------------------------------------
   always @(posedge clock) begin
      if (sys_rst) begin
         powerGood_ff <= 1'b0;
         acLossSeen_ff <= 1'b0;
         orderlyOff_ff <= 1'b0;
         windowBusy_ff <= 1'b0;
      end else begin
         // External good when wired, else own monitors
         powerGood_ff <= mainOn_ff & (powerGoodConnected ? power_good_in
                                     : (inputRailOk & moduleRailsOk)); // see R14
         windowBusy_ff <= (nxt_state == ST_WATCH);
         // Loss during window classified as AC loss
         if (stbLost && state_ff == ST_WATCH) begin
            acLossSeen_ff <= 1'b1; // see R3
            orderlyOff_ff <= 1'b0;
         end else if (winDone) begin
            orderlyOff_ff <= 1'b1; // see R2
            acLossSeen_ff <= 1'b0;
         end else if (nxt_state == ST_WATCH && state_ff != ST_WATCH) begin
            orderlyOff_ff <= 1'b0;
            acLossSeen_ff <= 1'b0;
         end
      end
   end
endmodule // plr_power_loss_ctrl

// ===== hw/plr_retain_mem.v
// Purpose: small retained memory for last state across power loss
// Assumes: contents survive standby loss (battery backed cell)
// Notes: registered read data; no reset on the array
`timescale 1ns/100ps
module plr_retain_mem #(
   parameter WIDTH = 8,
   parameter ADDR_W = 2
) (
   // Clock
   input wire clock,
   // Write port
   input wire wrEn,
   input wire [ADDR_W-1:0] wrAddr,
   input wire [WIDTH-1:0] wrData,
   // Read port
   input wire [ADDR_W-1:0] rdAddr,
   output reg [WIDTH-1:0] rdData_ff
);
   // Storage array
   reg [WIDTH-1:0] mem [0:(1<<ADDR_W)-1];

   // Write and registered read
   always @(posedge clock) begin
      if (wrEn) begin
         mem[wrAddr] <= wrData;
      end
      rdData_ff <= mem[rdAddr];
   end
endmodule // plr_retain_mem

// ===== verification/plr_carrier_model.sv
// Purpose: carrier power supply and push-button
// Assumes: controls driven off the clock edge
// Notes: main rail good trails suspend by one cycle
`timescale 1ns/100ps
module plr_carrier_model (
   // Clock
   input wire clock,
   // Controls
   input wire press,
   input wire acOff,
   input wire noStandby,
   // Module pins
   input wire suspend_rail_off_n,
   output wire power_button_n,
   output wire standby_5v_rail,
   output reg power_good_in = 1'b0
);
   // Unwired button pin reads high through the pull-up
   assign power_button_n = noStandby | ~press;
   // Standby present unless mains is cut
   assign standby_5v_rail = ~acOff;
   // Main rails follow the suspend output, gated off while mains is cut
   always @(posedge clock) begin
      power_good_in <= suspend_rail_off_n & ~acOff;
   end
endmodule // plr_carrier_model

// ===== verification/plr_power_loss_ctrl_asserts.sv
// Purpose: temporal checks of power loss recovery control
// Assumes: bound to plr_power_loss_ctrl, single clock domain
// Notes: window length comes from the bound parameter
`timescale 1ns/100ps
`include "plr_defines.vh"
module plr_power_loss_ctrl_asserts #(
   parameter WINDOW_CYC = 20
) (
   // Clock and reset
   input wire clock,
   input wire sys_rst,
   // Inputs
   input wire power_button_n,
   input wire powerGoodConnected,
   input wire standby_5v_rail,
   input wire standbySupported,
   input wire [1:0] recoveryMode,
   input wire [1:0] buttonMode,
   input wire osShutdownReq,
   input wire osWakeReq,
   input wire inputRailOk,
   input wire moduleRailsOk,
   // Outputs
   input wire suspend_rail_off_n,
   input wire powerGood_ff,
   input wire acLossSeen_ff,
   input wire windowBusy_ff
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (sys_rst);
   // Cycles the window has run so far
   reg [31:0] busyCnt_ff;
   always @(posedge clock) begin
      busyCnt_ff <= (sys_rst || !windowBusy_ff) ? 32'h0 : busyCnt_ff + 32'h1;
   end
   property p_loss_off;
      !standby_5v_rail |=> !suspend_rail_off_n;
   endproperty
   a_loss_off: assert property (p_loss_off) else $error("rails on without standby");
   property p_btn_tgl;
      $fell(power_button_n) && buttonMode == `PLR_BTN_TOGGLE && suspend_rail_off_n
         && standby_5v_rail && !osWakeReq |=> !suspend_rail_off_n;
   endproperty
   a_btn_tgl: assert property (p_btn_tgl) else $error("button did not switch off");
   property p_btn_ign;
      $fell(power_button_n) && buttonMode == `PLR_BTN_IGNORE && suspend_rail_off_n
         && standby_5v_rail && !osWakeReq && !osShutdownReq |=> $stable(suspend_rail_off_n);
   endproperty
   a_btn_ign: assert property (p_btn_ign) else $error("ignored button acted");
   property p_pg_own;
      !powerGoodConnected && inputRailOk && moduleRailsOk && suspend_rail_off_n
         && standby_5v_rail |=> powerGood_ff;
   endproperty
   a_pg_own: assert property (p_pg_own) else $error("no own power good");
   property p_win_mode;
      windowBusy_ff |-> $past(recoveryMode) == `PLR_MODE_LAST;
   endproperty
   a_win_mode: assert property (p_win_mode) else $error("window in wrong mode");
   property p_win_len;
      windowBusy_ff |-> busyCnt_ff < WINDOW_CYC;
   endproperty
   a_win_len: assert property (p_win_len) else $error("window too long");
   property p_ac_loss;
      windowBusy_ff && !standby_5v_rail |-> ##[1:2] acLossSeen_ff;
   endproperty
   a_ac_loss: assert property (p_ac_loss) else $error("loss not flagged");
   property p_ret_on;
      $rose(standby_5v_rail) && standbySupported && recoveryMode == `PLR_MODE_ON
         |-> ##[1:4] suspend_rail_off_n;
   endproperty
   a_ret_on: assert property (p_ret_on) else $error("no power up on return");
   property p_ret_off;
      $rose(standby_5v_rail) && standbySupported && recoveryMode == `PLR_MODE_OFF
         && !osWakeReq |-> !suspend_rail_off_n [*4];
   endproperty
   a_ret_off: assert property (p_ret_off) else $error("powered up in stay off");
   property p_no_sb;
      $rose(standby_5v_rail) && !standbySupported |-> ##[1:4] suspend_rail_off_n;
   endproperty
   a_no_sb: assert property (p_no_sb) else $error("mode used without standby");
   c_window: cover property ($rose(windowBusy_ff));
   c_loss: cover property ($rose(acLossSeen_ff));
   c_return: cover property ($rose(standby_5v_rail));
endmodule // plr_power_loss_ctrl_asserts
bind plr_power_loss_ctrl plr_power_loss_ctrl_asserts #(.WINDOW_CYC(WINDOW_CYC))
   plr_power_loss_ctrl_asserts_inst (.clock(clock), .sys_rst(sys_rst),
   .power_button_n(power_button_n), .powerGoodConnected(powerGoodConnected),
   .standby_5v_rail(standby_5v_rail), .standbySupported(standbySupported),
   .recoveryMode(recoveryMode), .buttonMode(buttonMode), .osShutdownReq(osShutdownReq),
   .osWakeReq(osWakeReq), .inputRailOk(inputRailOk), .moduleRailsOk(moduleRailsOk),
   .suspend_rail_off_n(suspend_rail_off_n), .powerGood_ff(powerGood_ff),
   .acLossSeen_ff(acLossSeen_ff), .windowBusy_ff(windowBusy_ff));

// ===== verification/tb_plr_power_loss_ctrl.sv
// Purpose: directed tests of power loss recovery control
// Assumes: short monitoring window
// Notes: carrier model supplies standby, button and power good
`timescale 1ns/100ps
`include "plr_defines.vh"
module tb_plr_power_loss_ctrl;
   localparam WIN = 20;
   reg clock = 1'b0, sys_rst = 1'b1, press = 1'b0, acOff = 1'b0, noSb = 1'b0;
   reg pgConn = 1'b1, sbSup = 1'b1, wake = 1'b0, ok = 1'b1, off = 1'b0;
   reg [1:0] rMode = `PLR_MODE_ON, bMode = `PLR_BTN_TOGGLE;
   wire btnN, sb, pgIn, rail, pg, acLoss, orderly, busy;
   integer n_fail = 0, tests_run = 0, cycles = 0;
   // Clock and hang limit
   initial begin
      forever #5 clock = ~clock;
   end
   always @(posedge clock) begin
      cycles = cycles + 1;
      if (cycles == 3000) begin
         n_fail = n_fail + 1;
         final_report;
      end
   end
   plr_carrier_model plr_carrier_model_inst (.clock(clock), .press(press), .acOff(acOff),
      .noStandby(noSb), .suspend_rail_off_n(rail), .power_button_n(btnN),
      .standby_5v_rail(sb), .power_good_in(pgIn));
   plr_power_loss_ctrl #(.WINDOW_CYC(WIN)) plr_power_loss_ctrl_inst (.clock(clock),
      .sys_rst(sys_rst), .power_button_n(btnN), .power_good_in(pgIn),
      .powerGoodConnected(pgConn), .standby_5v_rail(sb), .standbySupported(sbSup),
      .suspend_rail_off_n(rail), .recoveryMode(rMode), .buttonMode(bMode),
      .osShutdownReq(off), .osWakeReq(wake), .inputRailOk(ok), .moduleRailsOk(ok),
      .powerGood_ff(pg), .acLossSeen_ff(acLoss), .orderlyOff_ff(orderly),
      .windowBusy_ff(busy));
   task step(input integer n);
      begin
         repeat (n) @(posedge clock);
         #1;
      end
   endtask
   task chk(input [8*8:1] what, input exp, input got);
      begin
         tests_run = tests_run + 1;
         if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("FAIL %0s exp %b got %b", what, exp, got);
         end
      end
   endtask
   // Mains cut and restored
   task pcyc;
      begin
         acOff = 1'b1;
         step(2);
         chk("rail", 1'b0, rail);
         acOff = 1'b0;
         step(6);
      end
   endtask
   task push;
      begin
         press = 1'b1;
         step(2);
         press = 1'b0;
         step(3);
      end
   endtask
   task pulse_wake;
      begin
         wake = 1'b1;
         step(1);
         wake = 1'b0;
         step(2);
      end
   endtask
   task t_on_btn;
      begin
         pcyc;
         chk("rail", 1'b1, rail);
         chk("pg", 1'b1, pg);
         push;
         chk("rail", 1'b0, rail);
         chk("busy", 1'b0, busy);
         push;
         chk("rail", 1'b1, rail);
         bMode = `PLR_BTN_IGNORE;
         push;
         chk("rail", 1'b1, rail);
         bMode = `PLR_BTN_ON_ONLY;
         push;
         chk("rail", 1'b1, rail);
         bMode = `PLR_BTN_TOGGLE;
         $display("test on_btn done");
      end
   endtask
   task t_off;
      begin
         rMode = `PLR_MODE_OFF;
         pcyc;
         chk("rail", 1'b0, rail);
         pulse_wake;
         chk("rail", 1'b1, rail);
         $display("test off done");
      end
   endtask
   task t_last;
      begin
         rMode = `PLR_MODE_LAST;
         push;
         chk("busy", 1'b1, busy);
         step(WIN + 3);
         chk("orderly", 1'b1, orderly);
         chk("busy", 1'b0, busy);
         chk("acloss", 1'b0, acLoss);
         pcyc;
         chk("rail", 1'b0, rail);
         pulse_wake;
         pcyc;
         chk("rail", 1'b1, rail);
         push;
         step(3);
         pcyc;
         chk("acloss", 1'b1, acLoss);
         chk("rail", 1'b1, rail);
         $display("test last done");
      end
   endtask
   // Software off, on-only button, own power good, window abort
   task t_os;
      begin
         rMode = `PLR_MODE_ON;
         off = 1'b1;
         step(1);
         off = 1'b0;
         step(2);
         chk("rail", 1'b0, rail);
         chk("busy", 1'b0, busy);
         bMode = `PLR_BTN_ON_ONLY;
         push;
         chk("rail", 1'b1, rail);
         pgConn = 1'b0;
         ok = 1'b0;
         step(2);
         chk("pg", 1'b0, pg);
         pgConn = 1'b1;
         ok = 1'b1;
         bMode = `PLR_BTN_TOGGLE;
         rMode = `PLR_MODE_LAST;
         push;
         chk("busy", 1'b1, busy);
         rMode = `PLR_MODE_ON;
         step(2);
         chk("busy", 1'b0, busy);
         chk("orderly", 1'b0, orderly);
         chk("rail", 1'b0, rail);
         $display("test os done");
      end
   endtask
   task t_nosb;
      begin
         sbSup = 1'b0;
         noSb = 1'b1;
         pgConn = 1'b0;
         rMode = `PLR_MODE_OFF;
         pcyc;
         chk("rail", 1'b1, rail);
         chk("pg", 1'b1, pg);
         push;
         chk("rail", 1'b1, rail);
         $display("test nosb done");
      end
   endtask
   task final_report;
      begin
         $display("checks %0d fails %0d", tests_run, n_fail);
         if (n_fail == 0 && tests_run > 0) $display("ALL CHECKS OK");
         else $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   // Main sequence
   initial begin
      step(12);
      sys_rst = 1'b0;
      step(4);
      t_on_btn;
      t_off;
      t_last;
      t_os;
      t_nosb;
      final_report;
   end
endmodule // tb_plr_power_loss_ctrl
